// *** uiwl_pkg.sv ***
// Package of constants and types for the UART interrupt and wake-up block.
// What the document requires of this block and its software
// RULE1 - Sources: tx empty, tx idle, rx trigger, overrun, address, pin wake.
// RULE2 - An enabled condition reaches the controller as an active-low pulse.
// RULE3 - Each tx condition has its own enable; both rx conditions share one.
// RULE4 - Vector only with global and UART enables set, stack not full.
// RULE5 - Address detect interrupts without a status flag, only when enabled.
// RULE6 - Status flags are read-only and not cleared by vector entry.
// RULE7 - Address mode: rx interrupt only when top bit (9th or 8th) is high.
// RULE8 - Without address mode: rx interrupt each time the data flag sets; the code also requires rx_fifo_trig high.
// RULE9 - Software keeps parity off while address mode is on.
// RULE10 - Software sets UART and global enables for address interrupts.
// RULE11 - Clock stopped mid-frame freezes the transmitter until it returns.
// RULE12 - Idle or sleep during reception suspends reception, not aborts it.
// RULE13 - Idle or sleep leaves all UART registers unchanged.
// RULE14 - Clock off, all wake enables set: a falling pin edge wakes.
// RULE15 - Serial data during post-wake recovery is discarded.
// RULE16 - Without global or UART enable a pin wake only wakes, no interrupt.
// RULE17 - Wake interrupt waits until the recovery period has fully elapsed.
// RULE18 - Software confirms transfers finished before idle or sleep.
// RULE19 - Overrun requests an interrupt when the rx interrupt enable is set.
// RULE20 - All enabled, qualified sources are ORed onto one request line.
package uiwl_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL2 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;

  // Field positions in uart_control_two.
  localparam int C2_TXE_IE = 0;
  localparam int C2_TXI_IE = 1;
  localparam int C2_RX_IE = 2;
  localparam int C2_ADDR_DET = 3;
  localparam int C2_WAKE = 4;
  localparam int C2_NINE = 5;
  localparam int C2_PAR = 6;

  // Field positions in the first control register.
  localparam int C1_UEN = 0;
  localparam int C1_RX_ON = 1;
  localparam int C1_UART_IE = 2;
  localparam int C1_GLOBAL_IE = 3;

  // Field positions in uart_status_reg.
  localparam int ST_TXE = 0;
  localparam int ST_TXI = 1;
  localparam int ST_RXF = 2;
  localparam int ST_OVR = 3;

  // Reset values.
  localparam logic [6:0] CTRL2_RST = 7'h00;
  localparam logic [3:0] CTRL1_RST = 4'h0;

  // Post-wake clock recovery length, in system clock cycles.
  localparam int RECOV_CYCLES = 1024;

  // Interrupt source indices.
  localparam int SRC_TXE = 0;
  localparam int SRC_TXI = 1;
  localparam int SRC_RXT = 2;
  localparam int SRC_OVR = 3;
  localparam int SRC_ADR = 4;
  localparam int SRC_WAK = 5;
  localparam int NSRC = 6;

  // A received word handed over by the receiver core.
  typedef struct packed {
    logic valid;
    logic overrun;
    logic [8:0] word;
  } uiwl_rx_evt_t;

endpackage

// *** uiwl_recov_timer.sv ***
// Recovery timer that runs for a fixed number of cycles after a wake-up.
`timescale 1ns/10ps
module uiwl_recov_timer
  import uiwl_pkg::*;
#(
  parameter int CYCLES = RECOV_CYCLES
)
(
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic start, // Starts a recovery period.
  output logic busy, // High while recovery runs.
  output logic done // One-cycle pulse when recovery ends.
);

  logic [15:0] count;
  logic [15:0] next_count;
  logic next_busy;
  logic next_done;

  // Counts down the recovery period; a new start restarts it.
  always_comb
  begin
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    if (start)
    begin
      next_count = 16'(CYCLES - 1);
      next_busy = 1'b1;
    end
    else if (busy)
    begin
      if (count == 16'h0000)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
      else
      begin
        next_count = count - 16'h0001;
      end
    end
  end

  // Registers the timer state.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule

// *** uiwl_top.sv ***
// UART interrupt, address-detect and wake-up logic with an AHB-Lite slave.
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module uiwl_top
  import uiwl_pkg::*;
#(
  parameter int RECOV = RECOV_CYCLES
)
(
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic [31:0] hrdata, // Read data.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Response, always OKAY.
  input wire logic tx_empty, // Transmit data register empty.
  input wire logic tx_idle, // Transmitter idle.
  input wire uiwl_rx_evt_t rx_evt, // Word moved into the receive FIFO.
  input wire logic rx_fifo_trig, // Receive FIFO at trigger level.
  input wire logic uart_clk_on, // UART clock running.
  input wire logic core_sleep, // Core in idle or sleep.
  input wire logic rx_pin, // Serial pin level.
  input wire logic stack_full, // CPU call stack full.
  output logic irq_n, // Interrupt pulse, active low.
  output logic int_vector, // CPU vectors to UART routine.
  output logic wake_up, // Wake-up pulse to the core.
  output logic tx_freeze, // Transmitter holds its state.
  output logic rx_suspend, // Receiver pauses in place.
  output logic rx_discard, // Receiver drops incoming data.
  output logic data_pop // Data register read, pops the FIFO.
);

  //////////////////////////////////////////////////////////////////////////
  // Bus slave.

  logic [6:0] ctrl2;
  logic [3:0] ctrl1;
  logic [6:0] next_ctrl2;
  logic [3:0] next_ctrl1;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic next_wr_pend;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic next_pop;
  logic stat_armed;
  logic next_stat_armed;
  logic [3:0] status;
  logic [8:0] data_word;
  logic [8:0] next_data_word;
  logic acc;
  logic rd_status;
  logic rd_data;

  assign acc = hsel & htrans[1] & hready;
  assign rd_status = acc & !hwrite & (haddr[7:0] == OFF_STATUS);
  assign rd_data = acc & !hwrite & (haddr[7:0] == OFF_DATA);

  // Decodes accesses; writes land in the data phase, reads are registered.
  always_comb
  begin
    next_ctrl2 = ctrl2;
    next_ctrl1 = ctrl1;
    next_wr_pend = acc & hwrite;
    next_wr_addr = haddr[7:0];
    next_hrdata = hrdata;
    next_pop = rd_data;
    next_stat_armed = stat_armed;
    next_data_word = data_word;
    // Only bus writes move the control bits, never idle or sleep.
    if (wr_pend && wr_addr == OFF_CTRL2) // RULE13
    begin
      next_ctrl2 = hwdata[6:0];
    end
    if (wr_pend && wr_addr == OFF_CTRL1) // RULE13
    begin
      next_ctrl1 = hwdata[3:0];
    end
    if (acc && !hwrite)
    begin
      unique case (haddr[7:0])
        OFF_CTRL2: next_hrdata = {25'h0000000, ctrl2};
        OFF_CTRL1: next_hrdata = {28'h0000000, ctrl1};
        OFF_STATUS: next_hrdata = {28'h0000000, status};
        OFF_DATA: next_hrdata = {23'h000000, data_word};
        default: next_hrdata = 32'h00000000;
      endcase
    end
    // A status read arms the clear; the next data read fires it.
    if (rd_status)
    begin
      next_stat_armed = 1'b1;
    end
    else if (rd_data)
    begin
      next_stat_armed = 1'b0;
    end
    if (rx_evt.valid && !rx_discard)
    begin
      next_data_word = rx_evt.word;
    end
  end

  // Registers the bus state.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl2 <= CTRL2_RST;
      ctrl1 <= CTRL1_RST;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      data_pop <= 1'b0;
      stat_armed <= 1'b0;
      data_word <= 9'h000;
    end
    else
    begin
      ctrl2 <= next_ctrl2;
      ctrl1 <= next_ctrl1;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      data_pop <= next_pop;
      stat_armed <= next_stat_armed;
      data_word <= next_data_word;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status flags.

  logic rxf;
  logic ovr;
  logic next_rxf;
  logic next_ovr;
  logic clr_rx;

  // Only the status-then-data read sequence clears; setting wins the tie.
  assign clr_rx = rd_data & stat_armed; // RULE6
  always_comb
  begin
    next_rxf = rxf;
    next_ovr = ovr;
    if (clr_rx)
    begin
      next_rxf = 1'b0;
      next_ovr = 1'b0;
    end
    if (rx_evt.valid && !rx_discard)
    begin
      next_rxf = 1'b1;
    end
    if (rx_evt.valid && rx_evt.overrun && !rx_discard)
    begin
      next_ovr = 1'b1;
    end
  end

  // Registers the receive flags.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rxf <= 1'b0;
      ovr <= 1'b0;
    end
    else
    begin
      rxf <= next_rxf;
      ovr <= next_ovr;
    end
  end

  // Status readback, bus writes have no path into it.
  assign status = {ovr, rxf, tx_idle, tx_empty}; // RULE6

  //////////////////////////////////////////////////////////////////////////
  // Wake-up and low-power control.

  logic pin_d;
  logic next_pin_d;
  logic wake_evt;
  logic recov_busy;
  logic recov_done;
  logic wake_int;
  logic next_wake_int;
  logic next_wake_up;

  // Falling pin edge with the clock off and all wake enables set.
  assign wake_evt = !uart_clk_on & pin_d & !rx_pin & ctrl2[C2_WAKE]
    & ctrl1[C1_UEN] & ctrl1[C1_RX_ON] & ctrl2[C2_RX_IE]; // RULE14

  uiwl_recov_timer #(.CYCLES(RECOV)) u_recov (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(wake_evt),
    .busy(recov_busy),
    .done(recov_done)
  );

  // Wake interrupt only after recovery and only with both enables set.
  always_comb
  begin
    next_pin_d = rx_pin;
    next_wake_up = wake_evt;
    next_wake_int = recov_done & ctrl1[C1_GLOBAL_IE]
      & ctrl1[C1_UART_IE]; // RULE16 RULE17
  end

  // Registers wake state and the low-power controls.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_d <= 1'b1;
      wake_up <= 1'b0;
      wake_int <= 1'b0;
      tx_freeze <= 1'b0;
      rx_suspend <= 1'b0;
      rx_discard <= 1'b0;
    end
    else
    begin
      pin_d <= next_pin_d;
      wake_up <= next_wake_up;
      wake_int <= next_wake_int;
      tx_freeze <= !uart_clk_on; // RULE11
      rx_suspend <= core_sleep; // RULE12
      rx_discard <= wake_evt | recov_busy; // RULE15
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt sources and pulse.

  logic [NSRC-1:0] src;
  logic [NSRC-1:0] src_d;
  logic msb;
  logic rx_qual;
  logic any_new;

  // Top received bit depends on the word length.
  assign msb = ctrl2[C2_NINE] ? rx_evt.word[8] : rx_evt.word[7]; // RULE7
  assign rx_qual = !ctrl2[C2_ADDR_DET] | msb; // RULE7 RULE8
  // Enables gate each condition; rx trigger and overrun share one, wake arrives already gated.
  always_comb
  begin
    src = '0;
    src[SRC_TXE] = tx_empty & ctrl2[C2_TXE_IE]; // RULE1 RULE3
    src[SRC_TXI] = tx_idle & ctrl2[C2_TXI_IE]; // RULE3
    src[SRC_RXT] = rx_evt.valid & !rx_discard & rx_fifo_trig & rx_qual
      & ctrl2[C2_RX_IE]; // RULE3 RULE8
    src[SRC_OVR] = rx_evt.valid & !rx_discard & rx_evt.overrun
      & ctrl2[C2_RX_IE]; // RULE19
    src[SRC_ADR] = rx_evt.valid & !rx_discard & msb
      & ctrl2[C2_ADDR_DET]; // RULE5
    src[SRC_WAK] = wake_int; // RULE1
  end
  assign any_new = |(src & ~src_d); // RULE20

  // Turns each new request into a one-cycle low pulse, and a vector when both enables are set and the stack is not full.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      src_d <= '0;
      irq_n <= 1'b1;
      int_vector <= 1'b0;
    end
    else
    begin
      src_d <= src;
      irq_n <= !any_new; // RULE2
      int_vector <= any_new & ctrl1[C1_GLOBAL_IE] & ctrl1[C1_UART_IE]
        & !stack_full; // RULE4
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_irq_pulse;
    !irq_n |-> $past(any_new);
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) // RULE2
    else $error("irq pulse without a new source");

  property p_vec_gate;
    int_vector |-> !irq_n && $past(ctrl1[C1_GLOBAL_IE] && ctrl1[C1_UART_IE]
      && !stack_full);
  endproperty
  a_vec_gate: assert property (p_vec_gate) // RULE4
    else $error("vector taken while gated off");

  property p_adr_mask;
    rx_evt.valid && ctrl2[C2_ADDR_DET] && !msb |-> !src[SRC_RXT];
  endproperty
  a_adr_mask: assert property (p_adr_mask) // RULE7
    else $error("address mode passed a data word");

  property p_rx_plain;
    rx_evt.valid && !rx_discard && rx_fifo_trig && ctrl2[C2_RX_IE]
      && !ctrl2[C2_ADDR_DET] && !src_d[SRC_RXT] |=> !irq_n;
  endproperty
  a_rx_plain: assert property (p_rx_plain) // RULE8
    else $error("rx interrupt missing");

  property p_ovr_irq;
    rx_evt.valid && rx_evt.overrun && !rx_discard && ctrl2[C2_RX_IE]
      && !src_d[SRC_OVR] |=> !irq_n ##0 ovr;
  endproperty
  a_ovr_irq: assert property (p_ovr_irq) // RULE19
    else $error("overrun interrupt missing");

  property p_flag_hold;
    rxf && !clr_rx |=> rxf;
  endproperty
  a_flag_hold: assert property (p_flag_hold) // RULE6
    else $error("rx flag dropped without clear sequence");

  property p_wake_start;
    wake_evt |=> wake_up ##1 rx_discard;
  endproperty
  a_wake_start: assert property (p_wake_start) // RULE14
    else $error("wake not raised");

  property p_wake_late;
    wake_int |-> $past(recov_done) && !recov_busy;
  endproperty
  a_wake_late: assert property (p_wake_late) // RULE17
    else $error("wake interrupt before recovery ended");

  property p_wake_gate;
    wake_int |-> ctrl1[C1_GLOBAL_IE] || $past(ctrl1[C1_GLOBAL_IE]);
  endproperty
  a_wake_gate: assert property (p_wake_gate) // RULE16
    else $error("wake interrupt with global enable clear");

  property p_freeze;
    !uart_clk_on |=> tx_freeze;
  endproperty
  a_freeze: assert property (p_freeze) // RULE11
    else $error("transmitter not frozen");

  c_rx: cover property (rx_evt.valid ##1 !irq_n);
  c_wake: cover property (wake_up ##[1:1000] wake_int);
  c_clear: cover property (rd_status ##[1:8] clr_rx);
  c_vec: cover property (int_vector);

endmodule

// *** uiwl_far_end.sv ***
// Far-end model: remote sender that hands words over and drives the pin.
`timescale 1ns/10ps
module uiwl_far_end
  import uiwl_pkg::*;
(
  input wire logic hclk, // System clock.
  output uiwl_rx_evt_t rx_evt, // Word handed to the block.
  output logic rx_pin // Serial pin, idles high.
);
  // The pin idles high and no word is offered at start.
  initial
  begin
    rx_evt = '0;
    rx_pin = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // One word as a one-cycle pulse; the word lines then show the inverted word.
  task automatic send(input logic [8:0] w, input logic ovr);
    @(posedge hclk);
    rx_evt <= '{valid: 1'b1, overrun: ovr, word: w};
    @(posedge hclk);
    rx_evt <= '{valid: 1'b0, overrun: 1'b0, word: ~w};
  endtask

  // A start-bit style falling edge, held low a few cycles, then idle.
  task automatic fall();
    @(posedge hclk);
    rx_pin <= 1'b0;
    repeat (3) @(posedge hclk);
    rx_pin <= 1'b1;
  endtask
endmodule

// *** uiwl_top_tb.sv ***
// Self-checking testbench for the UART interrupt and wake-up block.
`timescale 1ns/10ps
module uiwl_top_tb;
  import uiwl_pkg::*;
  localparam int RC = 8;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = '0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic tx_empty = 1'b0;
  logic tx_idle = 1'b0;
  uiwl_rx_evt_t rx_evt;
  logic rx_fifo_trig = 1'b0;
  logic uart_clk_on = 1'b1;
  logic core_sleep = 1'b0;
  logic rx_pin;
  logic stack_full = 1'b0;
  logic irq_n, int_vector, wake_up, tx_freeze, rx_suspend, rx_discard;
  logic data_pop;
  int n_fail = 0;
  int cmp_count = 0;
  int n_irq = 0;
  int n_vec = 0;
  int n_wake = 0;
  int n_pop = 0;
  int cyc = 0;

  assign hready = hreadyout;

  // Clock of 50 ns period.
  always #25 hclk = ~hclk;

  uiwl_top #(.RECOV(RC)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tx_empty(tx_empty),
    .tx_idle(tx_idle), .rx_evt(rx_evt), .rx_fifo_trig(rx_fifo_trig),
    .uart_clk_on(uart_clk_on), .core_sleep(core_sleep), .rx_pin(rx_pin),
    .stack_full(stack_full), .irq_n(irq_n), .int_vector(int_vector),
    .wake_up(wake_up), .tx_freeze(tx_freeze), .rx_suspend(rx_suspend),
    .rx_discard(rx_discard), .data_pop(data_pop));

  uiwl_far_end fe (.hclk(hclk), .rx_evt(rx_evt), .rx_pin(rx_pin));

  //////////////////////////////////////////////////////////////////////////
  // Counts pulses on settled outputs and cuts a hang short.
  always @(negedge hclk)
  begin
    cyc++;
    if (irq_n === 1'b0) n_irq++;
    if (int_vector === 1'b1) n_vec++;
    if (wake_up === 1'b1) n_wake++;
    if (data_pop === 1'b1) n_pop++;
    if (cyc > 3000)
    begin
      n_fail++;
      $display("Timeout at %0t", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // One single AHB-Lite word transfer; waits on ready in both phases.
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, e);
    check({31'h0, hresp}, 32'h0);
  endtask

  // Waits n cycles and compares the interrupt and vector pulse counts.
  task automatic irq_win(input int n, input int ei, input int ev);
    int i0;
    int v0;
    i0 = n_irq;
    v0 = n_vec;
    repeat (n) @(posedge hclk);
    check(32'(n_irq - i0), 32'(ei));
    check(32'(n_vec - v0), 32'(ev));
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    check({31'h0, irq_n}, 32'h1);
    rd_chk(OFF_CTRL2, 32'h0);
    wr(OFF_CTRL2, 32'h77);
    rd_chk(OFF_CTRL2, 32'h77);
    wr(OFF_STATUS, 32'hF);
    rd_chk(OFF_STATUS, 32'h0);
    rd_chk(8'h10, 32'h0);
    wr(OFF_CTRL2, 32'h0);
    $display("Test regs done");
  endtask

  task automatic t_tx();
    wr(OFF_CTRL1, 32'hF);
    wr(OFF_CTRL2, 32'h1);
    tx_empty <= 1'b1;
    irq_win(6, 1, 1);
    tx_idle <= 1'b1;
    irq_win(6, 0, 0);
    rd_chk(OFF_STATUS, 32'h3);
    stack_full <= 1'b1;
    wr(OFF_CTRL2, 32'h3);
    irq_win(6, 1, 0);
    stack_full <= 1'b0;
    wr(OFF_CTRL1, 32'h3);
    tx_idle <= 1'b0;
    irq_win(2, 0, 0);
    tx_idle <= 1'b1;
    irq_win(6, 1, 0);
    wr(OFF_CTRL1, 32'hF);
    wr(OFF_CTRL2, 32'h0);
    tx_empty <= 1'b0;
    tx_idle <= 1'b0;
    $display("Test tx done");
  endtask

  task automatic t_rx();
    int p0;
    wr(OFF_CTRL2, 32'h4);
    rx_fifo_trig <= 1'b1;
    fe.send(9'h012, 1'b0);
    irq_win(6, 1, 1);
    p0 = n_pop;
    rd_chk(OFF_STATUS, 32'h4);
    rd_chk(OFF_DATA, 32'h012);
    check(32'(n_pop - p0), 32'h1);
    rd_chk(OFF_STATUS, 32'h0);
    fe.send(9'h055, 1'b1);
    irq_win(6, 1, 1);
    rd_chk(OFF_STATUS, 32'hC);
    rd_chk(OFF_DATA, 32'h055);
    wr(OFF_CTRL2, 32'h0);
    fe.send(9'h033, 1'b0);
    irq_win(6, 0, 0);
    $display("Test rx done");
  endtask

  task automatic t_addr();
    wr(OFF_CTRL2, 32'hC);
    fe.send(9'h07F, 1'b0);
    irq_win(6, 0, 0);
    fe.send(9'h080, 1'b0);
    irq_win(6, 1, 1);
    wr(OFF_CTRL2, 32'h2C);
    fe.send(9'h080, 1'b0);
    irq_win(6, 0, 0);
    fe.send(9'h100, 1'b0);
    irq_win(6, 1, 1);
    wr(OFF_CTRL2, 32'h08);
    rx_fifo_trig <= 1'b0;
    fe.send(9'h080, 1'b0);
    irq_win(6, 1, 1);
    rd_chk(OFF_STATUS, 32'h4);
    rd_chk(OFF_DATA, 32'h080);
    $display("Test address done");
  endtask

  task automatic t_sleep();
    core_sleep <= 1'b1;
    uart_clk_on <= 1'b0;
    repeat (3) @(posedge hclk);
    check({31'h0, rx_suspend}, 32'h1);
    check({31'h0, tx_freeze}, 32'h1);
    rd_chk(OFF_CTRL2, 32'h08);
    rd_chk(OFF_CTRL1, 32'hF);
    core_sleep <= 1'b0;
    $display("Test sleep done");
  endtask

  task automatic t_wake();
    int w0;
    int i0;
    wr(OFF_CTRL2, 32'h14);
    rx_fifo_trig <= 1'b1;
    w0 = n_wake;
    i0 = n_irq;
    fe.fall();
    check({31'h0, rx_discard}, 32'h1);
    check(32'(n_wake - w0), 32'h1);
    check(32'(n_irq - i0), 32'h0);
    fe.send(9'h0AA, 1'b0);
    irq_win(RC + 8, 1, 1);
    rd_chk(OFF_STATUS, 32'h0);
    wr(OFF_CTRL1, 32'h3);
    w0 = n_wake;
    fe.fall();
    irq_win(RC + 8, 0, 0);
    check(32'(n_wake - w0), 32'h1);
    wr(OFF_CTRL2, 32'h4);
    w0 = n_wake;
    fe.fall();
    irq_win(RC + 8, 0, 0);
    check(32'(n_wake - w0), 32'h0);
    uart_clk_on <= 1'b1;
    repeat (3) @(posedge hclk);
    check({31'h0, tx_freeze}, 32'h0);
    $display("Test wake done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for two cycles, then every test in turn.
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_addr();
    t_sleep();
    t_wake();
    close_out();
  end
endmodule
